// file: core/qei_core.sv
// quadrature encoder decoder with position, velocity, events and apb registers
//
// Function
// - phase mode: leading channel gives direction
// - clock/direction: step per rising edge, direction input level
// - count first channel or both channels
// - swap exchanges channels before decoding
// - index resets position when enabled
// - limit bounds position; reverse index loads limit
// - velocity counts pulses per equal period
// - running and latched velocity readable
// - velocity counts only while enabled
// - flags for index, period, direction, error
// - per-source mask gates interrupt
// - error set when both channels change together in phase mode
// - direction status holds last movement
// - clear drops chosen flags only
// - disable stops decoding and counting
// - velocity predivider power of two to 128
// - period in clocks, save and restart
// - software can write position
// - raw and masked flags readable
`timescale 1ns/10ps
`include "qei_map.svh"
module qei_core #(
	parameter int ADDR_W = 12
) (
	input  wire logic              clock_i,
	input  wire logic              rstn_i,
	input  wire logic              clk_en_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              phase_input_first_i,
	input  wire logic              phase_input_second_i,
	input  wire logic              index_i,
	output logic                   irq_o
);
	// sync stages: meta, stable, previous
	logic [2:0] s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt;
	logic [10:0] ctrl_r, ctrl_nxt;
	logic        err_r, err_nxt, dir_r, dir_nxt;
	qei_pkg::qei_word_t pos_r, pos_nxt, lim_r, lim_nxt, per_r, per_nxt, tmr_r, tmr_nxt;
	qei_pkg::qei_word_t vrun_r, vrun_nxt, vlast_r, vlast_nxt;
	logic [6:0]  pdiv_r, pdiv_nxt;
	logic [3:0]  ev_r, ev_nxt, msk_r, msk_nxt;
	logic [31:0] prdata_nxt;
	logic        pready_nxt, pslverr_nxt, irq_nxt;

	function automatic logic [6:0] div_mask(input logic [2:0] sel);
		div_mask = 7'((8'h01 << sel) - 8'h01);
	endfunction

	function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [11:0] off);
		is_addr = (a[11:0] == off);
	endfunction

	logic a_c, b_c, a_p, b_p, i_c, i_p, ch_a, ch_b, en, idx_rise;
	logic cnt_pulse, err_now, per_end;
	qei_pkg::qei_step_t step;
	logic acc_wr, acc_rd, wr_pos;

	always_comb begin
		a_c = ctrl_r[`QEI_CTRL_SWAP] ? s2_r[1] : s2_r[0];
		b_c = ctrl_r[`QEI_CTRL_SWAP] ? s2_r[0] : s2_r[1];
		a_p = ctrl_r[`QEI_CTRL_SWAP] ? s3_r[1] : s3_r[0];
		b_p = ctrl_r[`QEI_CTRL_SWAP] ? s3_r[0] : s3_r[1];
		i_c = s2_r[2];
		i_p = s3_r[2];
		ch_a = a_c ^ a_p;
		ch_b = b_c ^ b_p;
		en = ctrl_r[`QEI_CTRL_ENABLE];
		idx_rise = en & i_c & ~i_p;
		step = qei_pkg::QEI_DIR_HOLD;
		err_now = 1'b0;
		if (!en) begin
			step = qei_pkg::QEI_DIR_HOLD;
		end else if (ctrl_r[`QEI_CTRL_CLKDIR]) begin
			if (ch_a && a_c) begin
				step = b_c ? qei_pkg::QEI_DIR_REV : qei_pkg::QEI_DIR_FWD;
			end
		end else if (ch_a && ch_b) begin
			err_now = 1'b1;
		end else if (ch_a) begin
			step = (a_c ^ b_c) ? qei_pkg::QEI_DIR_FWD : qei_pkg::QEI_DIR_REV;
		end else if (ch_b && ctrl_r[`QEI_CTRL_BOTH]) begin
			step = (a_c ^ b_c) ? qei_pkg::QEI_DIR_REV : qei_pkg::QEI_DIR_FWD;
		end
		cnt_pulse = (step != qei_pkg::QEI_DIR_HOLD);
		per_end = en & ctrl_r[`QEI_CTRL_VEL_EN] & (tmr_r + 32'h00000001 >= per_r);
		acc_wr = psel_i & penable_i & pwrite_i & ~pready_o;
		acc_rd = psel_i & penable_i & ~pwrite_i & ~pready_o;
		wr_pos = acc_wr & is_addr(paddr_i, `QEI_OFF_POS);
	end

	always_comb begin
		s1_nxt = {index_i, phase_input_second_i, phase_input_first_i};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		ctrl_nxt = ctrl_r;
		lim_nxt = lim_r;
		per_nxt = per_r;
		msk_nxt = msk_r;
		err_nxt = err_r | err_now;
		dir_nxt = dir_r;
		pos_nxt = pos_r;
		ev_nxt = ev_r;
		if (step == qei_pkg::QEI_DIR_FWD) begin
			dir_nxt = 1'b0;
		end else if (step == qei_pkg::QEI_DIR_REV) begin
			dir_nxt = 1'b1;
		end
		if (wr_pos) begin
			pos_nxt = pwdata_i;
		end else if (idx_rise && ctrl_r[`QEI_CTRL_IDXRST]) begin
			pos_nxt = dir_nxt ? lim_r : 32'h00000000;
		end else if (step == qei_pkg::QEI_DIR_FWD) begin
			pos_nxt = (pos_r >= lim_r) ? 32'h00000000 : pos_r + 32'h00000001;
		end else if (step == qei_pkg::QEI_DIR_REV) begin
			pos_nxt = (pos_r == 32'h00000000) ? lim_r : pos_r - 32'h00000001;
		end
		// velocity: predivider, period timer
		pdiv_nxt = pdiv_r;
		vrun_nxt = vrun_r;
		vlast_nxt = vlast_r;
		tmr_nxt = tmr_r;
		if (en && ctrl_r[`QEI_CTRL_VEL_EN]) begin
			if (cnt_pulse) begin
				pdiv_nxt = (pdiv_r & div_mask(ctrl_r[`QEI_CTRL_DIV_HI:`QEI_CTRL_DIV_LO])) == 7'h00
				    ? 7'h01 : pdiv_r + 7'h01;
				pdiv_nxt = pdiv_nxt & div_mask(ctrl_r[`QEI_CTRL_DIV_HI:`QEI_CTRL_DIV_LO]);
			end
			if (per_end) begin
				tmr_nxt = 32'h00000000;
				vlast_nxt = vrun_r + {31'h0, cnt_pulse && pdiv_nxt == 7'h00};
				vrun_nxt = 32'h00000000;
			end else begin
				tmr_nxt = tmr_r + 32'h00000001;
				vrun_nxt = vrun_r + {31'h0, cnt_pulse && pdiv_nxt == 7'h00};
			end
		end else begin
			tmr_nxt = 32'h00000000;
			pdiv_nxt = 7'h00;
		end
		prdata_nxt = 32'h00000000;
		pready_nxt = acc_wr | acc_rd;
		pslverr_nxt = 1'b0;
		if (acc_wr) begin
			if (is_addr(paddr_i, `QEI_OFF_CTRL)) begin
				ctrl_nxt = pwdata_i[10:0];
			end else if (is_addr(paddr_i, `QEI_OFF_LIMIT)) begin
				lim_nxt = pwdata_i;
			end else if (is_addr(paddr_i, `QEI_OFF_PERIOD)) begin
				per_nxt = (pwdata_i == 32'h00000000) ? `QEI_PERIOD_RESET : pwdata_i;
			end else if (is_addr(paddr_i, `QEI_OFF_EV_MASK)) begin
				msk_nxt = pwdata_i[3:0];
			end else if (is_addr(paddr_i, `QEI_OFF_EV_CLEAR)) begin
				ev_nxt = ev_nxt & ~pwdata_i[3:0];
				err_nxt = err_nxt & ~pwdata_i[`QEI_EV_ERROR];
			end else if (!is_addr(paddr_i, `QEI_OFF_POS)) begin
				pslverr_nxt = 1'b1;
			end
		end
		if (acc_rd) begin
			if (is_addr(paddr_i, `QEI_OFF_CTRL)) begin
				prdata_nxt = {21'h0, ctrl_r};
			end else if (is_addr(paddr_i, `QEI_OFF_STAT)) begin
				prdata_nxt = {30'h0, dir_r, err_r};
			end else if (is_addr(paddr_i, `QEI_OFF_POS)) begin
				prdata_nxt = pos_r;
			end else if (is_addr(paddr_i, `QEI_OFF_LIMIT)) begin
				prdata_nxt = lim_r;
			end else if (is_addr(paddr_i, `QEI_OFF_PERIOD)) begin
				prdata_nxt = per_r;
			end else if (is_addr(paddr_i, `QEI_OFF_VEL_RUN)) begin
				prdata_nxt = vrun_r;
			end else if (is_addr(paddr_i, `QEI_OFF_VEL_LAST)) begin
				prdata_nxt = vlast_r;
			end else if (is_addr(paddr_i, `QEI_OFF_EV_MASK)) begin
				prdata_nxt = {28'h0, msk_r};
			end else if (is_addr(paddr_i, `QEI_OFF_EV_RAW)) begin
				prdata_nxt = {28'h0, ev_r};
			end else if (is_addr(paddr_i, `QEI_OFF_EV_MASKED)) begin
				prdata_nxt = {28'h0, ev_r & msk_r};
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
		// hardware sets win over the software clear
		if (per_end) begin
			ev_nxt[`QEI_EV_PERIOD] = 1'b1;
		end
		if (idx_rise) begin
			ev_nxt[`QEI_EV_INDEX] = 1'b1;
		end
		if (dir_nxt != dir_r) begin
			ev_nxt[`QEI_EV_DIR] = 1'b1;
		end
		if (err_now) begin
			ev_nxt[`QEI_EV_ERROR] = 1'b1;
			err_nxt = 1'b1;
		end
		irq_nxt = |(ev_nxt & msk_nxt);
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
			ctrl_r <= 11'h000;
			lim_r <= `QEI_LIMIT_RESET;
			per_r <= `QEI_PERIOD_RESET;
			msk_r <= 4'h0;
			err_r <= 1'b0;
			dir_r <= 1'b0;
			pos_r <= 32'h00000000;
			ev_r <= 4'h0;
			pdiv_r <= 7'h00;
			vrun_r <= 32'h00000000;
			vlast_r <= 32'h00000000;
			tmr_r <= 32'h00000000;
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			irq_o <= 1'b0;
		end else if (clk_en_i) begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			ctrl_r <= ctrl_nxt;
			lim_r <= lim_nxt;
			per_r <= per_nxt;
			msk_r <= msk_nxt;
			err_r <= err_nxt;
			dir_r <= dir_nxt;
			pos_r <= pos_nxt;
			ev_r <= ev_nxt;
			pdiv_r <= pdiv_nxt;
			vrun_r <= vrun_nxt;
			vlast_r <= vlast_nxt;
			tmr_r <= tmr_nxt;
			prdata_o <= prdata_nxt;
			pready_o <= pready_nxt;
			pslverr_o <= pslverr_nxt;
			irq_o <= irq_nxt;
		end
	end

	// checks
	irq_mask_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		clk_en_i |=> (irq_o == |($past(ev_nxt) & $past(msk_nxt))))
		else $error("irq does not follow masked flags");
	dis_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(clk_en_i && !en && !wr_pos) |=> $stable(pos_r))
		else $error("position moved while disabled");
	err_set_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(clk_en_i && err_now) |=> (err_r && ev_r[`QEI_EV_ERROR]))
		else $error("phase error not flagged");
	vel_off_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(clk_en_i && !en) |=> (tmr_r == 32'h00000000))
		else $error("velocity timer ran while disabled");
	pos_wr_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(clk_en_i && wr_pos) |=> (pos_r == $past(pwdata_i)))
		else $error("position write lost");
	dir_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(clk_en_i && step == qei_pkg::QEI_DIR_HOLD) |=> $stable(dir_r))
		else $error("direction changed without movement");
	fwd_wrap_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(clk_en_i && !wr_pos && !idx_rise && step == qei_pkg::QEI_DIR_FWD && pos_r == lim_r)
		|=> (pos_r == 32'h00000000))
		else $error("forward wrap failed");
	idx_rev_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(clk_en_i && !wr_pos && idx_rise && ctrl_r[`QEI_CTRL_IDXRST] && dir_nxt)
		|=> (pos_r == $past(lim_r)))
		else $error("reverse index did not load limit");
	apb_ans_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(clk_en_i && psel_i && penable_i && !pready_o) |=> pready_o)
		else $error("apb answer late");
	err_cov: cover property (@(posedge clock_i) disable iff (!rstn_i) err_now);
	per_cov: cover property (@(posedge clock_i) disable iff (!rstn_i) ev_r[`QEI_EV_PERIOD]);
	idx_cov: cover property (@(posedge clock_i) disable iff (!rstn_i)
		idx_rise && ctrl_r[`QEI_CTRL_IDXRST]);
	irq_cov: cover property (@(posedge clock_i) disable iff (!rstn_i) irq_o);
endmodule

// file: shared/qei_map.svh
// register offsets, field positions and reset values of the encoder block
`ifndef QEI_MAP_SVH
`define QEI_MAP_SVH
`define QEI_OFF_CTRL      12'h000
`define QEI_OFF_STAT      12'h004
`define QEI_OFF_POS       12'h008
`define QEI_OFF_LIMIT     12'h00C
`define QEI_OFF_PERIOD    12'h010
`define QEI_OFF_VEL_RUN   12'h014
`define QEI_OFF_VEL_LAST  12'h018
`define QEI_OFF_EV_MASK   12'h01C
`define QEI_OFF_EV_RAW    12'h020
`define QEI_OFF_EV_MASKED 12'h024
`define QEI_OFF_EV_CLEAR  12'h028
`define QEI_CTRL_ENABLE   0
`define QEI_CTRL_VEL_EN   1
`define QEI_CTRL_CLKDIR   2
`define QEI_CTRL_BOTH     3
`define QEI_CTRL_SWAP     4
`define QEI_CTRL_IDXRST   5
`define QEI_CTRL_DIV_LO   6
`define QEI_CTRL_DIV_HI   8
`define QEI_STAT_ERROR    0
`define QEI_STAT_DIR      1
`define QEI_EV_INDEX      0
`define QEI_EV_PERIOD     1
`define QEI_EV_DIR        2
`define QEI_EV_ERROR      3
`define QEI_LIMIT_RESET   32'hFFFFFFFF
`define QEI_PERIOD_RESET  32'h00000001
`endif

// file: shared/qei_pkg.sv
// types shared by the encoder block
package qei_pkg;
	typedef enum logic [1:0] {
		QEI_DIR_HOLD = 2'b00,
		QEI_DIR_FWD  = 2'b01,
		QEI_DIR_REV  = 2'b10
	} qei_step_t;
	typedef logic [31:0] qei_word_t;
endpackage

// file: test/qei_enc_model.sv
// behavioural quadrature encoder driving both channels and the index line
`timescale 1ns/10ps
module qei_enc_model (
	input  wire logic clock_i,
	input  wire logic step_i,
	input  wire logic rev_i,
	input  wire logic bad_i,
	input  wire logic mark_i,
	input  wire logic cdir_i,
	output logic      first_o,
	output logic      second_o,
	output logic      index_o
);
	logic [1:0] ph_r  = 2'b00;
	logic       dir_r = 1'b0;
	logic       idx_r = 1'b0;
	// gray phase: forward step lets the first channel lead by a quarter cycle
	always @(posedge clock_i) begin
		if (bad_i)
			ph_r <= ph_r + 2'd2;
		else if (step_i)
			ph_r <= rev_i ? ph_r - 2'd1 : ph_r + 2'd1;
		dir_r <= rev_i;
		idx_r <= mark_i;
	end
	assign first_o  = cdir_i ? ph_r[0] : ph_r[1] ^ ph_r[0];
	assign second_o = cdir_i ? dir_r : ph_r[1];
	assign index_o  = idx_r;
endmodule

// file: test/tb_top.sv
// self-checking bench: apb master, encoder model and a position model
`timescale 1ns/10ps
`include "qei_map.svh"
module tb_top;
	logic               clock_i = 1'b0;
	logic               rstn_i  = 1'b0;
	logic               psel, pen, pwr, prdy, perr, irq, e;
	logic               st, rv, bd, mk, phase_input_first, phase_input_second, ndx;
	logic [11:0]        padr;
	qei_pkg::qei_word_t pwd, prd, q;
	logic [31:0]        rs = 32'h8057AB89;
	logic [1:0]         ph = 2'b00;
	int                 err_total = 0, cmp_count = 0, pos = 0, lim = 9, ev = 0;
	bit                 en, cd, bo, sw, ix, dr, se;
	always #5 clock_i = ~clock_i;
	qei_core i_qei_core (.clock_i(clock_i), .rstn_i(rstn_i), .clk_en_i(1'b1),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .phase_input_first_i(phase_input_first),
		.phase_input_second_i(phase_input_second), .index_i(ndx), .irq_o(irq));
	qei_enc_model i_qei_enc_model (.clock_i(clock_i), .step_i(st), .rev_i(rv),
		.bad_i(bd), .mark_i(mk), .cdir_i(cd), .first_o(phase_input_first), .second_o(phase_input_second), .index_o(ndx));
	function automatic int rnd(input int n);
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return int'(rs % n);
	endfunction
	task automatic test_done();
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input qei_pkg::qei_word_t s, input qei_pkg::qei_word_t x);
		cmp_count++;
		if (s !== x) begin
			err_total++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, s, x);
		end
	endtask
	task automatic ap(input bit w, input logic [11:0] a, input qei_pkg::qei_word_t d = 32'h0);
		int t;
		t = 0;
		@(posedge clock_i);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clock_i);
		pen <= 1'b1;
		do begin
			@(posedge clock_i);
			t++;
		end while (prdy !== 1'b1 && t < 20);
		if (t >= 20)
			err_total++;
		q = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// n encoder steps, each followed by the expected position, direction and events
	task automatic mv(input bit r, input int n);
		logic [1:0] o;
		bit         fw, hit;
		repeat (n) begin
			rv <= r;
			repeat (2) @(posedge clock_i);
			st <= 1'b1;
			@(posedge clock_i);
			st <= 1'b0;
			repeat (6) @(posedge clock_i);
			o = ph;
			ph = r ? ph - 2'd1 : ph + 2'd1;
			fw = cd ? !r : (r == sw);
			hit = cd ? ph[0] : bo || (sw ? o[1] != ph[1] : ^o != ^ph);
			if (en && hit) begin
				pos = fw ? (pos == lim ? 0 : pos + 1) : (pos == 0 ? lim : pos - 1);
				if (dr == fw)
					ev |= 4;
				dr = !fw;
			end
		end
	endtask
	task automatic cfg(input qei_pkg::qei_word_t c);
		while (ph != 2'b00)
			mv(1'b0, 1);
		ap(1'b1, `QEI_OFF_CTRL, c & 32'hFFFFFFFE);
		{ix, sw, bo} = c[5:3];
		cd <= c[2];
		ap(1'b1, `QEI_OFF_CTRL, c);
		en = c[0];
	endtask
	task automatic idx();
		mk <= 1'b1;
		repeat (3) @(posedge clock_i);
		mk <= 1'b0;
		repeat (6) @(posedge clock_i);
		if (en) begin
			ev |= 1;
			if (ix)
				pos = dr ? lim : 0;
		end
	endtask
	task automatic bad();
		bd <= 1'b1;
		@(posedge clock_i);
		bd <= 1'b0;
		repeat (6) @(posedge clock_i);
		ph = ph + 2'd2;
		ev |= 8;
		se = 1;
	endtask
	task automatic clr(input int m);
		ap(1'b1, `QEI_OFF_EV_CLEAR, m);
		ev &= ~m;
		se = se && !m[3];
	endtask
	task automatic chk_st();
		ap(1'b0, `QEI_OFF_POS);
		chk(q, pos);
		ap(1'b0, `QEI_OFF_STAT);
		chk(q & 32'h3, {dr, se});
		ap(1'b0, `QEI_OFF_EV_RAW);
		chk(q & 32'hD, ev);
	endtask
	task automatic chk_irq(input int m);
		ap(1'b1, `QEI_OFF_EV_MASK, m);
		ap(1'b0, `QEI_OFF_EV_MASKED);
		chk(q, ev & m);
		chk({31'h0, irq}, (ev & m) != 0);
	endtask
	task automatic wt();
		int t;
		t = 0;
		q = 32'h0;
		while (q[1] !== 1'b1 && t < 200) begin
			ap(1'b0, `QEI_OFF_EV_RAW);
			t++;
		end
		chk(q[1], 1'b1);
	endtask
	task automatic vel(input int dv, input int n, input int x);
		cfg(32'hB | (dv << 6));
		clr(2);
		wt();
		clr(2);
		mv(1'b0, n);
		ap(1'b0, `QEI_OFF_VEL_RUN);
		if (dv == 0)
			chk(q, n);
		wt();
		ap(1'b0, `QEI_OFF_VEL_LAST);
		chk(q, x);
	endtask
	initial begin
		{psel, pen, pwr, st, rv, bd, mk, padr, pwd} = '0;
		repeat (4) @(posedge clock_i);
		rstn_i <= 1'b1;
		ap(1'b0, `QEI_OFF_CTRL);
		chk(q, 32'h0);
		ap(1'b0, `QEI_OFF_LIMIT);
		chk(q, `QEI_LIMIT_RESET);
		ap(1'b0, 12'h0FC);
		chk({q[30:0], e}, 32'h1);
		ap(1'b1, `QEI_OFF_PERIOD, 32'h0);
		ap(1'b0, `QEI_OFF_PERIOD);
		chk(q, `QEI_PERIOD_RESET);
		ap(1'b1, `QEI_OFF_LIMIT, lim);
		for (int m = 0; m < 4; m++) begin
			cfg(1 | (m << 3));
			mv(1'b0, rnd(10) + 2);
			chk_st();
			mv(1'b1, rnd(10) + 2);
			idx();
			chk_st();
		end
		pos = rnd(lim);
		ap(1'b1, `QEI_OFF_POS, pos);
		mv(1'b0, 2);
		chk_st();
		cfg(32'h8);
		mv(1'b0, 3);
		chk_st();
		cfg(32'h9);
		clr(15);
		bad();
		chk_st();
		chk_irq(8);
		chk_irq(4);
		mv(!dr, 2);
		clr(8);
		chk_st();
		chk_irq(8);
		chk_irq(4);
		cfg(32'h29);
		mv(1'b0, 3);
		idx();
		chk_st();
		mv(1'b1, 2);
		idx();
		chk_st();
		cfg(32'h5);
		mv(1'b0, rnd(8) + 2);
		chk_st();
		mv(1'b1, rnd(8) + 2);
		chk_st();
		ap(1'b1, `QEI_OFF_PERIOD, 32'd300);
		vel(0, 4, 4);
		vel(2, 8, 2);
		cfg(32'hA);
		mv(1'b0, 3);
		ap(1'b0, `QEI_OFF_VEL_RUN);
		chk(q, 32'h0);
		test_done();
	end
	initial begin
		repeat (40000) @(posedge clock_i);
		err_total++;
		test_done();
	end
endmodule
